/* File: logic/hardware_limit_period_timer.sv */
// 8-bit period timer with hardware limit control
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "hlt_timer_cfg.svh"
module hardware_limit_period_timer (
    input  wire logic                      sys_clk,          // 250 MHz clock
    input  wire logic                      rst_n,            // async reset, low
    input  wire hlt_timer_pkg::reg_req_s   reg_req,          // register request
    output logic [7:0]                     reg_rdata,        // read data, next cycle
    input  wire logic [3:0]                ext_src,          // external reset sources
    input  wire logic                      dbg_freeze,       // debug freeze, same clock
    output logic                           postscaled_pulse, // adc trigger / shutdown
    output hlt_timer_pkg::pwm_link_s       pwm_link          // live state to pwm
);
    logic                       run_q;
    logic [2:0]                 presc_sel_q;
    logic [3:0]                 post_sel_q;
    logic [4:0]                 mode_q;
    logic                       sync_q;
    logic [1:0]                 src_sel_q;
    logic [7:0]                 count_q;
    logic [7:0]                 period_q;
    logic                       running_q;
    logic [3:0]                 post_cnt_q;
    logic                       pulse_q;
    logic [3:0]                 sync1_q;
    logic [3:0]                 sync2_q;
    logic                       ers_tick_q;
    logic                       ers_prev_q;
    logic [7:0]                 rdata_q;
    logic                       tick;
    logic [6:0]                 presc_cnt;
    logic                       wr_count;
    logic                       wr_period;
    logic                       wr_ctrl;
    logic                       wr_mode;
    logic                       wr_src;
    logic                       ers_seen;
    logic                       rise;
    logic                       fall;
    logic                       on_rise;
    logic                       start_evt;
    logic                       reset_evt;
    logic                       gate_ok;
    logic                       counting;
    logic                       match;
    logic                       post_hit;
    logic                       adv;
    logic                       stop;
    logic                       clr;
    logic [2:0]                 sub;
    hlt_timer_pkg::mode_group_e grp;

    assign wr_count  = reg_req.wr && reg_req.addr == `OFF_COUNT;
    assign wr_period = reg_req.wr && reg_req.addr == `OFF_PERIOD;
    assign wr_ctrl   = reg_req.wr && reg_req.addr == `OFF_CTRL;
    assign wr_mode   = reg_req.wr && reg_req.addr == `OFF_MODE;
    assign wr_src    = reg_req.wr && reg_req.addr == `OFF_SRC;

    assign grp = hlt_timer_pkg::mode_group_e'(mode_q[4:3]);
    assign sub = mode_q[2:0];

    // two-stage synchronisers on the external pins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= ext_src;
            sync2_q <= sync1_q;
        end
    end

    // synchronous mode samples the source on ticks only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ers_tick_q <= 1'b0;
        end else if (tick) begin
            ers_tick_q <= sync2_q[src_sel_q];
        end
    end

    // freeze holds the seen level, so no edge and no level change
    assign ers_seen = dbg_freeze ? ers_prev_q :
                      (sync_q ? ers_tick_q : sync2_q[src_sel_q]);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ers_prev_q <= 1'b0;
        end else begin
            ers_prev_q <= ers_seen;
        end
    end

    assign rise    = ers_seen && !ers_prev_q;
    assign fall    = !ers_seen && ers_prev_q;
    assign on_rise = wr_ctrl && reg_req.wdata[`CTRL_RUN] && !run_q;

    // start triggers for one-shot and monostable groups
    always_comb begin
        start_evt = 1'b0;
        unique case (grp)
            hlt_timer_pkg::GRP_ONESHOT: begin
                unique case (sub)
                    3'h0:             start_evt = on_rise;
                    3'h1, 3'h4, 3'h6: start_evt = run_q && rise;
                    3'h2, 3'h5, 3'h7: start_evt = run_q && fall;
                    3'h3:             start_evt = run_q && (rise || fall);
                endcase
            end
            hlt_timer_pkg::GRP_MONO: begin
                // external event restarts after a stop
                unique case (sub)
                    3'h1:    start_evt = run_q && rise;
                    3'h2:    start_evt = run_q && fall;
                    3'h3:    start_evt = run_q && (rise || fall);
                    3'h6:    start_evt = run_q && ers_seen && !running_q;
                    3'h7:    start_evt = run_q && !ers_seen && !running_q;
                    default: start_evt = 1'b0;
                endcase
            end
            hlt_timer_pkg::GRP_FREE, hlt_timer_pkg::GRP_RSVD: start_evt = 1'b0;
        endcase
    end

    // reset on configured level or edge
    always_comb begin
        reset_evt = 1'b0;
        unique case (grp)
            hlt_timer_pkg::GRP_FREE: begin
                unique case (sub)
                    3'h3:    reset_evt = rise || fall;
                    3'h4:    reset_evt = rise;
                    3'h5:    reset_evt = fall;
                    3'h6:    reset_evt = !ers_seen;
                    3'h7:    reset_evt = ers_seen;
                    default: reset_evt = 1'b0;
                endcase
            end
            hlt_timer_pkg::GRP_ONESHOT: begin
                unique case (sub)
                    3'h4:    reset_evt = rise;
                    3'h5:    reset_evt = fall;
                    3'h6:    reset_evt = !ers_seen;
                    3'h7:    reset_evt = ers_seen;
                    default: reset_evt = 1'b0;
                endcase
            end
            hlt_timer_pkg::GRP_MONO: begin
                reset_evt = (sub == 3'h6 && !ers_seen) || (sub == 3'h7 && ers_seen);
            end
            hlt_timer_pkg::GRP_RSVD: reset_evt = 1'b0;
        endcase
    end

    assign gate_ok  = (sub == 3'h1) ? ers_seen : ((sub == 3'h2) ? !ers_seen : 1'b1);
    assign counting = run_q && ((grp == hlt_timer_pkg::GRP_FREE) ? gate_ok : running_q);
    assign match    = count_q == period_q;
    assign post_hit = post_cnt_q == post_sel_q;
    assign adv      = tick && counting && match;
    assign stop     = adv && (grp != hlt_timer_pkg::GRP_FREE);
    assign clr      = wr_count || wr_ctrl || reset_evt || start_evt;

    hlt_prescaler u_presc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (clr),
        .sel     (presc_sel_q),
        .tick    (tick),
        .cnt     (presc_cnt)
    );

    // software access, period resets to ff
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_q <= `PERIOD_RST;
        end else if (wr_period) begin
            period_q <= reg_req.wdata;
        end
    end

    // increment on tick, clear after match, one-shot and monostable stop at 00h
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= `COUNT_RST;
        end else if (wr_count) begin
            count_q <= reg_req.wdata;
        end else if (reset_evt || (start_evt && grp == hlt_timer_pkg::GRP_MONO)) begin
            count_q <= 8'h00;
        end else if (tick && counting) begin
            count_q <= match ? 8'h00 : count_q + 8'h01;
        end
    end

    // one-shot clears run bit; software write wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q       <= 1'(`CTRL_RST >> `CTRL_RUN);
            presc_sel_q <= 3'h0;
            post_sel_q  <= 4'h0;
        end else if (wr_ctrl) begin
            run_q       <= reg_req.wdata[`CTRL_RUN];
            presc_sel_q <= reg_req.wdata[`CTRL_PRE_HI:`CTRL_PRE_LO];
            post_sel_q  <= reg_req.wdata[`CTRL_POST_HI:`CTRL_POST_LO];
        end else if (stop && grp == hlt_timer_pkg::GRP_ONESHOT) begin
            run_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q    <= `MODE_RST;
            sync_q    <= 1'b0;
            src_sel_q <= `SRC_RST;
        end else begin
            if (wr_mode) begin
                mode_q <= reg_req.wdata[4:0];
                sync_q <= reg_req.wdata[`MODE_SYNC];
            end
            if (wr_src) begin
                src_sel_q <= reg_req.wdata[1:0];
            end
        end
    end

    // monostable stop leaves run bit set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            running_q <= 1'b0;
        end else if (start_evt) begin
            // software start fires while run_q is still low
            running_q <= 1'b1;
        end else if (!run_q) begin
            running_q <= 1'b0;
        end else if (stop) begin
            running_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            post_cnt_q <= 4'h0;
            pulse_q    <= 1'b0;
        end else if (clr) begin
            post_cnt_q <= 4'h0;
            pulse_q    <= 1'b0;
        end else if (adv) begin
            post_cnt_q <= post_hit ? 4'h0 : post_cnt_q + 4'h1;
            pulse_q    <= post_hit;
        end else if (tick) begin
            pulse_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                `OFF_COUNT:  rdata_q <= count_q;
                `OFF_PERIOD: rdata_q <= period_q;
                `OFF_CTRL:   rdata_q <= {run_q, presc_sel_q, post_sel_q};
                `OFF_MODE:   rdata_q <= {sync_q, 2'h0, mode_q};
                `OFF_SRC:    rdata_q <= {6'h00, src_sel_q};
                `OFF_STATUS: rdata_q <= {5'h00, ers_seen, pulse_q, counting};
                default:     rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // exports to adc, shutdown and pwm
    assign reg_rdata        = rdata_q;
    assign postscaled_pulse = pulse_q;
    assign pwm_link         = '{count: count_q, match: match, tick: tick, counting: counting};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_count_wraps: assert property (adv && !wr_count && !reset_evt |=> count_q == 8'h00)
        else $error("count not cleared after match");
    a_count_incr: assert property (tick && counting && !match && !wr_count && !reset_evt
        && !start_evt |=> count_q == $past(count_q) + 8'h01)
        else $error("count did not increment on tick");
    a_pulse_hold: assert property (pulse_q && !tick && !clr |=> pulse_q)
        else $error("pulse shorter than one tick");
    a_ctrl_keep: assert property (wr_ctrl && !tick && !reset_evt && !start_evt
        |=> count_q == $past(count_q))
        else $error("control write changed count");
    a_presc_clear: assert property (wr_ctrl |=> presc_cnt == 7'h00)
        else $error("prescaler not cleared by control write");
    a_oneshot_stop: assert property (stop && grp == hlt_timer_pkg::GRP_ONESHOT && !wr_ctrl
        && !wr_count |=> !run_q && count_q == 8'h00 ##1 count_q == 8'h00)
        else $error("one-shot did not stop at zero");
    a_mono_keep: assert property (stop && grp == hlt_timer_pkg::GRP_MONO && !wr_ctrl
        && !start_evt |=> run_q && !running_q)
        else $error("monostable stop wrong");
    a_gate_hold: assert property (grp == hlt_timer_pkg::GRP_FREE && sub == 3'h1 && !ers_seen
        && !wr_count |=> count_q == $past(count_q))
        else $error("count moved with gate closed");
    a_ext_reset: assert property (reset_evt && !wr_count |=> count_q == 8'h00)
        else $error("external reset did not clear count");
    a_freeze_edges: assert property (dbg_freeze |-> !rise && !fall)
        else $error("edge seen during freeze");
    a_period_reset: assert property ($rose(rst_n) |-> period_q == 8'hff)
        else $error("period reset value wrong");

    c_pulse: cover property (pulse_q && post_sel_q == 4'hf);
    c_oneshot: cover property (stop && grp == hlt_timer_pkg::GRP_ONESHOT);
    c_mono_restart: cover property (grp == hlt_timer_pkg::GRP_MONO && start_evt && run_q);
    c_ext_reset: cover property (reset_evt && grp == hlt_timer_pkg::GRP_FREE);

endmodule : hardware_limit_period_timer

/* File: logic/hlt_timer_cfg.svh */
// constants for the hardware limit period timer
`ifndef HLT_TIMER_CFG_SVH
`define HLT_TIMER_CFG_SVH

`define OFF_COUNT    3'h0
`define OFF_PERIOD   3'h1
`define OFF_CTRL     3'h2
`define OFF_MODE     3'h3
`define OFF_SRC      3'h4
`define OFF_STATUS   3'h5

`define CTRL_RUN     7
`define CTRL_PRE_HI  6
`define CTRL_PRE_LO  4
`define CTRL_POST_HI 3
`define CTRL_POST_LO 0
`define MODE_SYNC    7

`define COUNT_RST    8'h00
`define PERIOD_RST   8'hff
`define CTRL_RST     8'h00
`define MODE_RST     5'h00
`define SRC_RST      2'h0

`endif

/* File: logic/hlt_timer_pkg.sv */
// types shared by the hardware limit period timer
package hlt_timer_pkg;

    typedef enum logic [1:0] {
        GRP_FREE    = 2'b00,
        GRP_ONESHOT = 2'b01,
        GRP_MONO    = 2'b10,
        GRP_RSVD    = 2'b11
    } mode_group_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic [7:0] count;
        logic       match;
        logic       tick;
        logic       counting;
    } pwm_link_s;

    function automatic logic [6:0] presc_mask(input logic [2:0] sel);
        presc_mask = 7'(8'h01 << sel) - 7'h01;
    endfunction : presc_mask

endpackage : hlt_timer_pkg

/* File: logic/hlt_prescaler.sv */
// prescaler producing the one-cycle timer tick
`timescale 1ns/10ps
module hlt_prescaler (
    input  wire logic       sys_clk,  // system clock
    input  wire logic       rst_n,    // async reset, low
    input  wire logic       clear,    // restart division
    input  wire logic [2:0] sel,      // ratio 2^sel
    output logic            tick,     // one-cycle tick
    output logic [6:0]      cnt       // division counter
);
    logic [6:0] cnt_q;

    assign tick = (cnt_q & hlt_timer_pkg::presc_mask(sel)) == hlt_timer_pkg::presc_mask(sel);
    assign cnt  = cnt_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 7'h00;
        end else if (clear || tick) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

endmodule : hlt_prescaler

/* File: dv/pwm_consumer_model.sv */
// on-chip consumer of the postscaled pulse and the live timer link
`timescale 1ns/10ps
module pwm_consumer_model (
    input  wire logic                     sys_clk, // system clock
    input  wire logic                     rst_n,   // async reset, low
    input  wire logic                     pulse,   // postscaled pulse
    input  wire hlt_timer_pkg::pwm_link_s link,    // live timer state
    output logic [15:0]                   n_pulse, // rising edges seen
    output logic [15:0]                   gap,     // cycles between rises
    output logic [15:0]                   width,   // cycles of last high
    output logic [15:0]                   run_cyc  // cycles spent counting
);
    logic [15:0] since_q;
    logic [15:0] hi_q;
    logic        pulse_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= 1'b0;
            since_q <= 16'h0000;
            hi_q    <= 16'h0000;
            n_pulse <= 16'h0000;
            gap     <= 16'h0000;
            width   <= 16'h0000;
            run_cyc <= 16'h0000;
        end else begin
            pulse_q <= pulse;
            since_q <= (pulse && !pulse_q) ? 16'h0001 : since_q + 16'h0001;
            hi_q    <= pulse ? hi_q + 16'h0001 : 16'h0000;
            run_cyc <= link.counting ? run_cyc + 16'h0001 : run_cyc;
            if (pulse && !pulse_q) begin
                n_pulse <= n_pulse + 16'h0001;
                gap     <= since_q;
            end
            if (!pulse && pulse_q) begin
                width <= hi_q;
            end
        end
    end
endmodule : pwm_consumer_model

/* File: dv/hardware_limit_period_timer_test.sv */
// self-checking bench for the hardware limit period timer
`timescale 1ns/10ps
module hardware_limit_period_timer_test;
    logic                     sys_clk;
    logic                     rst_n;
    hlt_timer_pkg::reg_req_s  req;
    logic [7:0]               rdata;
    logic [3:0]               ext_src;
    logic                     dbg_freeze;
    logic                     pulse;
    hlt_timer_pkg::pwm_link_s link;
    logic [15:0]              n_pulse;
    logic [15:0]              gap;
    logic [15:0]              width;
    logic [15:0]              run_cyc;
    int                       mismatches = 0;
    int                       n_tests = 0;
    int                       cyc = 0;

    hardware_limit_period_timer dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req),
        .reg_rdata(rdata), .ext_src(ext_src), .dbg_freeze(dbg_freeze),
        .postscaled_pulse(pulse), .pwm_link(link));
    pwm_consumer_model far_u (.sys_clk(sys_clk), .rst_n(rst_n), .pulse(pulse), .link(link),
        .n_pulse(n_pulse), .gap(gap), .width(width), .run_cyc(run_cyc));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        n_tests++;
        if (s !== x) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge sys_clk);
        req <= '0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        req <= '0;
        #1 v = rdata;
    endtask : rd

    task automatic rdc(input logic [2:0] a, input logic [7:0] x);
        logic [7:0] v;
        rd(a, v);
        chk({8'h00, v}, {8'h00, x});
    endtask : rdc

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle

    task automatic set_ext(input logic v);
        @(posedge sys_clk);
        ext_src <= {3'h0, v};
        idle(8);
    endtask : set_ext

    task automatic wait_rises(input int k);
        logic [15:0] p;
        p = n_pulse;
        for (int i = 0; i < 4000 && n_pulse < p + 16'(k); i++) begin
            idle(1);
        end
    endtask : wait_rises

    task automatic t_regs();
        rdc(3'h0, 8'h00);
        rdc(3'h1, 8'hff);
        rdc(3'h2, 8'h00);
        rdc(3'h6, 8'h00);
        wr(3'h1, 8'h5a);
        rdc(3'h1, 8'h5a);
        wr(3'h0, 8'h33);
        rdc(3'h0, 8'h33);
        wr(3'h3, 8'h81);
        rdc(3'h3, 8'h81);
        wr(3'h4, 8'h03);
        rdc(3'h4, 8'h03);
        wr(3'h6, 8'hff);
        rdc(3'h6, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h00);
    endtask : t_regs

    task automatic t_scale();
        wr(3'h1, 8'h02);
        for (int s = 0; s < 8; s++) begin
            wr(3'h2, {1'b1, 3'(s), 4'h0});
            wait_rises(3);
            chk(gap, 16'd3 << s);
            chk(width, 16'd1 << s);
        end
        wr(3'h1, 8'h01);
        wr(3'h2, 8'h8f);
        wait_rises(3);
        chk(gap, 16'd32);
        chk(width, 16'd1);
        wr(3'h2, 8'h00);
    endtask : t_scale

    task automatic t_gate();
        logic [7:0] a;
        logic [7:0] b;
        set_ext(1'b0);
        wr(3'h3, 8'h81);
        wr(3'h1, 8'hff);
        wr(3'h2, 8'h80);
        idle(10);
        rd(3'h0, a);
        idle(10);
        rd(3'h0, b);
        chk({8'h00, b}, {8'h00, a});
        set_ext(1'b1);
        idle(10);
        rd(3'h0, a);
        chk(16'(a > b), 16'h0001);
        wr(3'h2, 8'h00);
        rd(3'h0, a);
        wr(3'h2, 8'h10);
        rd(3'h0, b);
        chk({8'h00, b}, {8'h00, a});
    endtask : t_gate

    task automatic t_level_reset();
        logic [7:0] a;
        wr(3'h3, 8'h07);
        wr(3'h2, 8'h80);
        idle(10);
        rdc(3'h0, 8'h00);
        set_ext(1'b0);
        idle(10);
        rd(3'h0, a);
        chk(16'(a != 8'h00), 16'h0001);
        rdc(3'h5, 8'h01);
        wr(3'h2, 8'h00);
    endtask : t_level_reset

    task automatic t_oneshot();
        logic [15:0] p;
        wr(3'h3, 8'h08);
        wr(3'h1, 8'h03);
        wr(3'h0, 8'h00);
        p = n_pulse;
        wr(3'h2, 8'h80);
        idle(30);
        rdc(3'h2, 8'h00);
        rdc(3'h0, 8'h00);
        chk({8'h00, link.count}, 16'h0000);
        chk({15'h0000, link.match}, 16'h0000);
        chk({15'h0000, link.counting}, 16'h0000);
        chk(n_pulse, p + 16'h0001);
        wr(3'h2, 8'h00);
        wr(3'h2, 8'h80);
        idle(30);
        chk(n_pulse, p + 16'h0002);
    endtask : t_oneshot

    task automatic t_mono();
        logic [15:0] p;
        wr(3'h3, 8'h11);
        wr(3'h2, 8'h80);
        p = n_pulse;
        idle(20);
        chk(n_pulse, p);
        set_ext(1'b1);
        idle(30);
        chk(n_pulse, p + 16'h0001);
        rdc(3'h2, 8'h80);
        rdc(3'h0, 8'h00);
        set_ext(1'b0);
        set_ext(1'b1);
        idle(30);
        chk(n_pulse, p + 16'h0002);
        @(posedge sys_clk);
        dbg_freeze <= 1'b1;
        set_ext(1'b0);
        set_ext(1'b1);
        idle(30);
        chk(n_pulse, p + 16'h0002);
        @(posedge sys_clk);
        dbg_freeze <= 1'b0;
        wr(3'h2, 8'h00);
    endtask : t_mono

    task automatic t_reserved();
        logic [15:0] r;
        wr(3'h3, 8'h18);
        wr(3'h0, 8'h00);
        r = run_cyc;
        wr(3'h2, 8'h80);
        idle(20);
        rdc(3'h0, 8'h00);
        chk(run_cyc, r);
        chk({15'h0000, link.tick}, 16'h0001);
    endtask : t_reserved

    initial begin
        req        = '0;
        ext_src    = 4'h0;
        dbg_freeze = 1'b0;
        rst_n      = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_scale();
        t_gate();
        t_level_reset();
        t_oneshot();
        t_mono();
        t_reserved();
        end_sim();
    end
endmodule : hardware_limit_period_timer_test
